/* File: hw/fpet_core.sv */
`timescale 1ns/1ps
module fpet_core (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic                  clk_en,
    input  wire logic [7:0]            op_clock_divider_reg,
    input  wire logic                  cmd_valid,
    input  wire fpet_pkg::fpet_cmd_e   cmd_code,
    input  wire logic                  burst_next,
    input  wire logic                  word_blank,
    output logic                       busy,
    output logic                       done,
    output logic                       ack,
    output logic                       blank_fail,
    output logic [15:0]                check_addr,
    output logic                       erase_pulse
);

    // ------------------------------------------------------------------
    // Operation clock tick
    // ------------------------------------------------------------------
    logic [7:0] div_cnt_q;
    logic       op_tick;
    logic       div_restart;

    // Divide by divider+1; the rate is not checked, any setting runs.
    // The count restarts when a timed phase begins, so no phase opens on a partial period.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            div_cnt_q <= fpet_pkg::FPET_DIV_RESET;
        end else if (clk_en) begin
            if (div_restart) begin
                div_cnt_q <= 8'h00;
            end else if (div_cnt_q >= op_clock_divider_reg) begin
                div_cnt_q <= 8'h00;
            end else begin
                div_cnt_q <= div_cnt_q + 8'h01;
            end
        end
    end
    assign op_tick = (div_cnt_q >= op_clock_divider_reg);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FPET_IDLE, FPET_OPPH, FPET_BUSPH, FPET_PULSE, FPET_SCAN
    } fpet_state_e;

    fpet_state_e        state_q;
    fpet_pkg::fpet_cmd_e cmd_q;
    logic [15:0]        op_left_q;
    logic [15:0]        bus_left_q;
    logic [6:0]         words_q;
    logic [4:0]         pulses_q;
    logic [16:0]        scan_q;
    logic               burst_go;

    // A burst goes on while the pipeline holds a word and the row is not yet full.
    assign burst_go = cmd_q == fpet_pkg::FPET_CMD_BURST_PGM && burst_next
                      && words_q < fpet_pkg::FPET_BURST_MAX_WORDS;

    // Every timed phase starts on a fresh operation clock period.
    assign div_restart = (state_q == FPET_IDLE && cmd_valid)
                         || (state_q == FPET_BUSPH && bus_left_q == 16'h0001 && burst_go)
                         || (state_q == FPET_PULSE && !erase_pulse);

    // Commands are taken only while idle, so every operation finishes first.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q     <= FPET_IDLE;
            cmd_q       <= fpet_pkg::FPET_CMD_WORD_PGM;
            op_left_q   <= 16'h0000;
            bus_left_q  <= 16'h0000;
            words_q     <= 7'h00;
            pulses_q    <= 5'h00;
            scan_q      <= 17'h00000;
            busy        <= 1'b0;
            done        <= 1'b0;
            ack         <= 1'b0;
            blank_fail  <= 1'b0;
            check_addr  <= 16'h0000;
            erase_pulse <= 1'b0;
        end else if (clk_en) begin
            ack <= 1'b0;
            case (state_q)
                FPET_IDLE: begin
                    if (cmd_valid) begin
                        cmd_q      <= cmd_code;
                        busy       <= 1'b1;
                        done       <= 1'b0;
                        blank_fail <= 1'b0;
                        words_q    <= 7'h01;
                        pulses_q   <= 5'h00;
                        scan_q     <= 17'h00000;
                        check_addr <= 16'h0000;
                        case (cmd_code)
                            fpet_pkg::FPET_CMD_WORD_PGM,
                            fpet_pkg::FPET_CMD_BURST_PGM: begin
                                op_left_q  <= fpet_pkg::FPET_WORD_OP_CYC;
                                bus_left_q <= fpet_pkg::FPET_WORD_BUS_CYC;
                                state_q    <= FPET_OPPH;
                            end
                            fpet_pkg::FPET_CMD_SECTOR_ERASE: begin
                                op_left_q   <= fpet_pkg::FPET_PULSE_OP_CYC;
                                erase_pulse <= 1'b1;
                                state_q     <= FPET_PULSE;
                            end
                            fpet_pkg::FPET_CMD_BLOCK_ERASE: begin
                                op_left_q   <= fpet_pkg::FPET_BLOCK_OP_CYC;
                                erase_pulse <= 1'b1;
                                pulses_q    <= 5'h0F;
                                state_q     <= FPET_PULSE;
                            end
                            default: begin
                                bus_left_q <= fpet_pkg::FPET_CHECK_SETUP_CYC;
                                state_q    <= FPET_SCAN;
                            end
                        endcase
                    end
                end
                FPET_OPPH: begin
                    // Operation clock share of a program word.
                    if (op_tick) begin
                        op_left_q <= op_left_q - 16'h0001;
                        if (op_left_q == 16'h0001) begin
                            state_q <= FPET_BUSPH;
                        end
                    end
                end
                FPET_BUSPH: begin
                    bus_left_q <= bus_left_q - 16'h0001;
                    if (bus_left_q == 16'h0001) begin
                        // Burst goes on while the pipeline holds the next word.
                        if (burst_go) begin
                            ack        <= 1'b1;
                            words_q    <= words_q + 7'h01;
                            op_left_q  <= fpet_pkg::FPET_BURST_OP_CYC;
                            bus_left_q <= fpet_pkg::FPET_BURST_BUS_CYC;
                            state_q    <= FPET_OPPH;
                        end else begin
                            busy    <= 1'b0;
                            done    <= 1'b1;
                            state_q <= FPET_IDLE;
                        end
                    end
                end
                FPET_PULSE: begin
                    // One quiet bus cycle between pulses keeps each pulse separate.
                    if (!erase_pulse) begin
                        erase_pulse <= 1'b1;
                    end else if (op_tick) begin
                        op_left_q <= op_left_q - 16'h0001;
                        if (op_left_q == 16'h0001) begin
                            if (pulses_q == fpet_pkg::FPET_ERASE_PULSES - 5'h01) begin
                                erase_pulse <= 1'b0;
                                busy        <= 1'b0;
                                done        <= 1'b1;
                                state_q     <= FPET_IDLE;
                            end else begin
                                erase_pulse <= 1'b0;
                                pulses_q  <= pulses_q + 5'h01;
                                op_left_q <= fpet_pkg::FPET_PULSE_OP_CYC;
                            end
                        end
                    end
                end
                FPET_SCAN: begin
                    // Setup first, then one word each bus cycle from zero upward.
                    if (bus_left_q != 16'h0000) begin
                        bus_left_q <= bus_left_q - 16'h0001;
                    end else if (!word_blank) begin
                        blank_fail <= 1'b1;
                        busy       <= 1'b0;
                        done       <= 1'b1;
                        state_q    <= FPET_IDLE;
                    end else if (scan_q == fpet_pkg::FPET_CHECK_WORDS - 17'h00001) begin
                        busy    <= 1'b0;
                        done    <= 1'b1;
                        state_q <= FPET_IDLE;
                    end else begin
                        scan_q     <= scan_q + 17'h00001;
                        check_addr <= scan_q[15:0] + 16'h0001;
                    end
                end
                default: begin
                    state_q <= FPET_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Completion, phase loads and counters; the covers mark the main scenarios.
    a_done_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(done) |-> !busy && state_q == FPET_IDLE)
        else $error("done without idle");
    a_busy_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        busy && state_q != FPET_IDLE |-> !$rose(done))
        else $error("done while busy");
    a_word_start: assert property (@(posedge clk_sys) disable iff (!nrst)
        state_q == FPET_IDLE && cmd_valid && clk_en
        && cmd_code == fpet_pkg::FPET_CMD_WORD_PGM
        |=> state_q == FPET_OPPH && op_left_q == fpet_pkg::FPET_WORD_OP_CYC)
        else $error("word program start wrong");
    a_burst_word: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(ack) |-> op_left_q == fpet_pkg::FPET_BURST_OP_CYC
        && bus_left_q == fpet_pkg::FPET_BURST_BUS_CYC)
        else $error("burst word timing wrong");
    a_burst_limit: assert property (@(posedge clk_sys) disable iff (!nrst)
        words_q <= fpet_pkg::FPET_BURST_MAX_WORDS)
        else $error("burst over row length");
    a_pulse_count: assert property (@(posedge clk_sys) disable iff (!nrst)
        pulses_q < fpet_pkg::FPET_ERASE_PULSES)
        else $error("too many erase pulses");
    a_pulse_gap: assert property (@(posedge clk_sys) disable iff (!nrst)
        state_q == FPET_PULSE && !erase_pulse && clk_en |=> erase_pulse)
        else $error("erase pulse gap too long");
    a_block_start: assert property (@(posedge clk_sys) disable iff (!nrst)
        state_q == FPET_IDLE && cmd_valid && clk_en
        && cmd_code == fpet_pkg::FPET_CMD_BLOCK_ERASE
        |=> erase_pulse && op_left_q == fpet_pkg::FPET_BLOCK_OP_CYC)
        else $error("block erase start wrong");
    a_scan_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
        state_q == FPET_SCAN && bus_left_q == 16'h0000 && !word_blank && clk_en
        |=> blank_fail && done)
        else $error("blank check did not stop");
    c_burst: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(ack));
    c_fail: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(blank_fail));
    c_erase: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(erase_pulse));

endmodule

/* File: shared/fpet_pkg.sv */
package fpet_pkg;

    // ------------------------------------------------------------------
    // Operation commands
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FPET_CMD_WORD_PGM,
        FPET_CMD_BURST_PGM,
        FPET_CMD_SECTOR_ERASE,
        FPET_CMD_BLOCK_ERASE,
        FPET_CMD_BLANK_CHECK
    } fpet_cmd_e;

    // ------------------------------------------------------------------
    // Timing figures, operation clock periods and bus clock periods
    // ------------------------------------------------------------------
    localparam int          FPET_SYS_CLK_KHZ      = 25000;
    localparam int          FPET_OP_RATE_MIN_KHZ  = 150;
    localparam int          FPET_OP_RATE_MAX_KHZ  = 200;
    localparam int          FPET_MIN_BUS_KHZ      = 1000;
    localparam logic [15:0] FPET_WORD_OP_CYC      = 16'h0009;
    localparam logic [15:0] FPET_WORD_BUS_CYC     = 16'h0019;
    localparam logic [15:0] FPET_BURST_OP_CYC     = 16'h0004;
    localparam logic [15:0] FPET_BURST_BUS_CYC    = 16'h0009;
    localparam logic [6:0]  FPET_BURST_MAX_WORDS  = 7'h40;
    localparam logic [4:0]  FPET_ERASE_PULSES     = 5'h10;
    localparam logic [15:0] FPET_PULSE_OP_CYC     = 16'h00FA;
    localparam logic [15:0] FPET_BLOCK_OP_CYC     = 16'h4E20;
    localparam logic [15:0] FPET_CHECK_SETUP_CYC  = 16'h000A;
    localparam logic [16:0] FPET_CHECK_WORDS      = 17'h10000;
    localparam logic [7:0]  FPET_DIV_RESET        = 8'h00;

endpackage

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
    logic                 clk_sys;
    logic                 nrst;
    logic                 clk_en;
    logic [7:0]           op_div;
    logic                 cmd_valid;
    fpet_pkg::fpet_cmd_e  cmd_code;
    logic                 burst_next;
    logic                 word_blank;
    logic                 busy;
    logic                 done;
    logic                 ack;
    logic                 blank_fail;
    logic [15:0]          check_addr;
    logic                 erase_pulse;
    logic [16:0]          dirty_addr;
    int                   num_errors;
    int                   n_compared;
    int                   n_cyc;
    int                   n;
    int                   acks;
    int                   pulses;

    fpet_core fpet_core_i (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
        .op_clock_divider_reg(op_div), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .burst_next(burst_next), .word_blank(word_blank), .busy(busy), .done(done),
        .ack(ack), .blank_fail(blank_fail), .check_addr(check_addr),
        .erase_pulse(erase_pulse));

    // ------------------------------------------------------------------
    // Clock, blank memory image and run limit
    // ------------------------------------------------------------------
    // Free running bus clock at 25 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // The memory answers for the address shown, so at most one word reads dirty.
    always @(negedge clk_sys) begin
        word_blank <= ({1'b0, check_addr} != dirty_addr);
    end

    // A hung operation must not stall the run forever.
    always @(posedge clk_sys) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 40000) begin
            num_errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Compare and drive tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_range(input string nm, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Mode 1 pokes a command while busy, mode 2 freezes the clock enable.
    task automatic run_op(input fpet_pkg::fpet_cmd_e code, input logic [7:0] dv,
                          input int mode);
        logic prev;
        n = 0;
        acks = 0;
        pulses = 0;
        prev = 1'b0;
        @(negedge clk_sys);
        op_div = dv;
        cmd_code = code;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        chk_val("busy", 16'h0001, {15'h0000, busy});
        while (done !== 1'b1 && n < 30000) begin
            if (ack === 1'b1) acks++;
            if (erase_pulse === 1'b1 && !prev) pulses++;
            prev = erase_pulse;
            n++;
            if (mode == 1 && n == 5) begin
                cmd_valid = 1'b1;
                cmd_code = fpet_pkg::FPET_CMD_BLOCK_ERASE;
            end
            if (mode == 1 && n == 6) cmd_valid = 1'b0;
            if (mode == 2 && n == 5) clk_en = 1'b0;
            if (mode == 2 && n == 15) clk_en = 1'b1;
            @(negedge clk_sys);
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Word time at several dividers; only the last keeps the clock in its band.
    task automatic test_word();
        int dvs[3];
        dvs = '{0, 3, 124};
        foreach (dvs[i]) begin
            run_op(fpet_pkg::FPET_CMD_WORD_PGM, dvs[i][7:0], 0);
            chk_range("word", 9 * (dvs[i] + 1) + 24, 9 * (dvs[i] + 1) + 27 + dvs[i], n);
        end
    endtask

    // A burst with an empty pipeline is one word; a full one runs 64 words.
    task automatic test_burst();
        run_op(fpet_pkg::FPET_CMD_BURST_PGM, 8'h00, 0);
        chk_range("burst1", 0, 0, acks);
        chk_range("burst1 time", 33, 36, n);
        burst_next = 1'b1;
        run_op(fpet_pkg::FPET_CMD_BURST_PGM, 8'h00, 0);
        burst_next = 1'b0;
        chk_range("burst acks", 63, 63, acks);
        chk_range("burst time", 34 + 63 * 13 - 2, 34 + 63 * 13 + 8, n);
    endtask

    // Sector erase in separate pulses, then the whole block.
    task automatic test_erase();
        run_op(fpet_pkg::FPET_CMD_SECTOR_ERASE, 8'h00, 0);
        chk_range("pulses", 16, 16, pulses);
        chk_range("sector", 3990, 4100, n);
        run_op(fpet_pkg::FPET_CMD_BLOCK_ERASE, 8'h00, 0);
        chk_range("block", 19800, 20200, n);
    endtask

    // Blank check stops at the first dirty word, at zero and further up.
    task automatic test_check();
        dirty_addr = 17'h00000;
        run_op(fpet_pkg::FPET_CMD_BLANK_CHECK, 8'h00, 0);
        chk_range("check0", 10, 12, n);
        chk_val("fail0", 16'h0001, {15'h0000, blank_fail});
        chk_val("addr0", 16'h0000, check_addr);
        dirty_addr = 17'h00025;
        run_op(fpet_pkg::FPET_CMD_BLANK_CHECK, 8'h00, 0);
        chk_range("check37", 10 + 37, 12 + 37, n);
        chk_val("fail37", 16'h0001, {15'h0000, blank_fail});
        chk_val("addr37", 16'h0025, check_addr);
        dirty_addr = 17'h10000;
    endtask

    // A command during an operation is dropped and never runs later.
    task automatic test_refuse();
        run_op(fpet_pkg::FPET_CMD_WORD_PGM, 8'h00, 1);
        chk_range("refused", 33, 36, n);
        chk_val("fail clear", 16'h0000, {15'h0000, blank_fail});
        repeat (3) @(negedge clk_sys);
        chk_val("done held", 16'h0001, {15'h0000, done});
        chk_val("idle", 16'h0000, {15'h0000, busy});
    endtask

    // Ten frozen cycles stretch the operation by exactly ten.
    task automatic test_freeze();
        run_op(fpet_pkg::FPET_CMD_WORD_PGM, 8'h00, 2);
        chk_range("frozen", 43, 46, n);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    // The blank image process alone drives word_blank, so it is left out here.
    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        op_div = 8'h00;
        cmd_valid = 1'b0;
        cmd_code = fpet_pkg::FPET_CMD_WORD_PGM;
        burst_next = 1'b0;
        dirty_addr = 17'h10000;
        num_errors = 0;
        n_compared = 0;
        repeat (6) @(negedge clk_sys);
        nrst = 1'b1;
        test_word();
        test_burst();
        test_erase();
        test_check();
        test_refuse();
        test_freeze();
        print_verdict();
    end
endmodule
